// [inc/asc_defs.vh]
// register offsets, field positions, reset values and codes of the afe setup block
`ifndef ASC_DEFS_VH
`define ASC_DEFS_VH

// register byte addresses on the axi4-lite bus
`define ASC_ADDR_SETUP1      4'h0
`define ASC_ADDR_SETUP2      4'h4
`define ASC_ADDR_STATUS      4'h8

// reset values
`define ASC_SETUP1_RST       8'h03
`define ASC_SETUP2_RST       4'h0

// power / sampling register fields
`define ASC_F_ENABLE         0
`define ASC_F_DSAMPLE        1
`define ASC_F_SINGLE         2
`define ASC_F_DUAL           3
`define ASC_F_OFFS_LO        4
`define ASC_F_OFFS_HI        5
`define ASC_F_FASTEST        6
`define ASC_F_COMPAT         7

// output format register fields
`define ASC_F_FMT_LO         0
`define ASC_F_FMT_HI         1
`define ASC_F_INVERT         2
`define ASC_F_OPDIS          3

// output format codes
`define ASC_FMT_BYTE         2'h1
`define ASC_FMT_NIBBLE       2'h3

// zero-input output codes
`define ASC_CODE_MID         16'h7fff
`define ASC_CODE_FULL        16'hffff
`define ASC_CODE_ZERO        16'h0000

// axi responses
`define ASC_RESP_OKAY        2'h0
`define ASC_RESP_SLVERR      2'h2

`endif

// [logic/asc_setup_ctrl.v]
// afe setup control: two setup registers, mode decode and output pin formatter
// Operation
// R1: enable clear powers whole device down
// R2: bit1 selects single-ended or double sampling
// R3: single channel uses selected input only
// R4: dual channel samples red and green
// R5: offset code sets zero-input output level
// R6: host sets inversion for zero-code negative video
// R7: fastest bit ignored without compatible timing
// R8: bit7 selects normal or compatible timing
// R9: host supplies double clock, pixel-rate sample
// R10: reset sample pin drives clamp/autocycle role
// R11: format: 8+8, upper byte, or nibbles
// R12: inversion bit inverts output data digitally
// R13: output disable bit tristates output pins
// R14: pins driven only when enable pin low
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "asc_defs.vh"

module asc_setup_ctrl (
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  // axi4-lite slave; only byte lane 0 of each word is kept,
  // the upper lanes read back as zero and writes to them are dropped
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // analogue core controls; all are levels that the core may sample
  // at any time, so each one leaves a flip-flop
  input  wire [1:0]  inputSelect,
  output reg         powerDown,
  output reg         doubleSampleEn,
  output reg  [2:0]  chanEnable,
  output reg  [15:0] zeroInputCode,
  output reg         compatTiming,
  output reg         compatMode4,
  input  wire        resetSamplePulse,
  output reg         clampAutocycle,
  // converted samples and output pins; the pins are released whenever
  // either the pin or the register bit asks for it
  input  wire [15:0] adcData,
  input  wire        adcValid,
  input  wire        outputEnableNPin,
  output reg  [7:0]  opData,
  output reg         opStrobe,
  output wire        opOe_n
);

  // setup register storage
  // both registers come out of reset in their defaults, so the device is
  // fully active with double sampling and three channels before software
  // has touched anything
  reg  [7:0]  setup1_r;            // power / sampling / timing
  reg  [3:0]  setup2_r;            // format / invert / disable
  // write channel capture
  // only lane 0 and its strobe are kept, the rest of the data is unused
  reg         awGot_r;             // address held, waiting for data
  reg         wGot_r;              // data held, waiting for address
  reg  [3:0]  awAddr_r;
  reg  [7:0]  wByte_r;
  reg         wStrb_r;
  // output formatter state
  // word_r holds the sample left-aligned; each slot shifts it up so the
  // next part always sits in the top bits
  reg  [15:0] word_r;              // sample being shifted out
  reg  [1:0]  slot_r;              // slots still to send after current
  reg  [1:0]  slot_nxt;
  reg  [15:0] word_nxt;

  // address decode shared by read and write paths
  // index 0 marks an unmapped address; both paths answer it with an
  // error response instead of aliasing it onto a real register
  function [1:0] decIdx;
    input [3:0] a;
    begin
      case (a)
        `ASC_ADDR_SETUP1: decIdx = 2'h1;
        `ASC_ADDR_SETUP2: decIdx = 2'h2;
        `ASC_ADDR_STATUS: decIdx = 2'h3;
        default:          decIdx = 2'h0;
      endcase
    end
  endfunction

  // field decodes
  // these are plain wires off the register; everything the core sees is
  // registered again further down
  wire        enable   = setup1_r[`ASC_F_ENABLE];
  wire        compat   = setup1_r[`ASC_F_COMPAT];
  wire [1:0]  ampOffsetSel   = setup1_r[`ASC_F_OFFS_HI:`ASC_F_OFFS_LO];
  wire [1:0]  outputFormatSel = setup2_r[`ASC_F_FMT_HI:`ASC_F_FMT_LO];
  wire        outputInvert   = setup2_r[`ASC_F_INVERT];
  wire        outputDisable  = setup2_r[`ASC_F_OPDIS];

  // nibble mode outside compatible timing falls back to 8+8, a safe default:
  // a receiver that expects whole bytes never sees half-filled pins
  // R11 format decode
  wire        fmtByte   = (outputFormatSel == `ASC_FMT_BYTE);
  wire        fmtNibble = (outputFormatSel == `ASC_FMT_NIBBLE) && compat;

  // the write completes when both halves are present, from regs or the bus
  // taking the late half straight off the bus saves one cycle per write;
  // the price is a mux in front of the register data path
  wire        awTake  = awvalid && awready;
  wire        wTake   = wvalid && wready;
  wire        haveAw  = awGot_r || awTake;
  wire        haveW   = wGot_r || wTake;
  wire        doWrite = haveAw && haveW;
  wire [3:0]  wrAddr  = awGot_r ? awAddr_r : awaddr;
  wire [7:0]  wrByte  = wGot_r ? wByte_r : wdata[7:0];
  wire        wrLane  = wGot_r ? wStrb_r : wstrb[0];

  // no new write is taken while a response is pending
  // this keeps at most one write in flight, so a single response register
  // is enough and no response can be lost
  assign awready = !awGot_r && !bvalid;
  assign wready  = !wGot_r && !bvalid;
  assign arready = !rvalid;

  // output enable is combinational so the pin takes effect at once,
  // matching an external enable that may be toggled between lines
  // R14 pin gates drive
  // R13 disable bit tristates
  assign opOe_n = outputEnableNPin || outputDisable;

  // write channel and register updates
  // a held half waits in awGot_r or wGot_r until its partner arrives;
  // ready stays low for that channel meanwhile
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      setup1_r <= `ASC_SETUP1_RST;
      setup2_r <= `ASC_SETUP2_RST;
      awGot_r  <= 1'b0;
      wGot_r   <= 1'b0;
      awAddr_r <= 4'h0;
      wByte_r  <= 8'h00;
      wStrb_r  <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= `ASC_RESP_OKAY;
    end else if (ce) begin
      // response leaves once accepted
      if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (doWrite) begin
        // both halves here: commit and answer
        awGot_r <= 1'b0;
        wGot_r  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= `ASC_RESP_OKAY;
        case (decIdx(wrAddr))
          2'h1: if (wrLane) setup1_r <= wrByte;
          2'h2: if (wrLane) setup2_r <= wrByte[3:0];
          2'h3: ; // status is read only, write ignored
          default: bresp <= `ASC_RESP_SLVERR;
        endcase
      end else begin
        // hold whichever half arrived first
        if (awTake) begin
          awGot_r  <= 1'b1;
          awAddr_r <= awaddr;
        end
        if (wTake) begin
          wGot_r  <= 1'b1;
          wByte_r <= wdata[7:0];
          wStrb_r <= wstrb[0];
        end
      end
    end
  end

  // read channel; status shows decoded block state
  // status bits: [2:0] channel enables, [4] double sampling, [5] power
  // down, [6] fastest compatible mode, [7] output pins driven
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `ASC_RESP_OKAY;
    end else if (ce) begin
      if (rvalid && rready) begin
        rvalid <= 1'b0;
      end else if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= `ASC_RESP_OKAY;
        case (decIdx(araddr))
          2'h1: rdata <= {24'h000000, setup1_r};
          2'h2: rdata <= {28'h0000000, setup2_r};
          2'h3: rdata <= {24'h000000, !opOe_n, compatMode4, powerDown,
                          doubleSampleEn, 1'b0, chanEnable};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `ASC_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // analogue core controls, registered so they glitch-free reach the core
  // every control follows its register one edge after the write; the
  // core must tolerate that one cycle in which old and new settings mix
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      powerDown      <= 1'b0;
      doubleSampleEn <= 1'b0;
      chanEnable     <= 3'h0;
      zeroInputCode  <= `ASC_CODE_MID;
      compatTiming   <= 1'b0;
      compatMode4    <= 1'b0;
      clampAutocycle <= 1'b0;
    end else if (ce) begin
      // R1 global enable powers down all
      powerDown <= !enable;
      // R2 sampling select
      doubleSampleEn <= enable && setup1_r[`ASC_F_DSAMPLE];
      if (!enable) begin
        chanEnable <= 3'h0;
      // single channel wins when both mode bits are set
      // R3 single channel select
      end else if (setup1_r[`ASC_F_SINGLE]) begin
        case (inputSelect)
          2'h0:    chanEnable <= 3'h1;
          2'h1:    chanEnable <= 3'h2;
          default: chanEnable <= 3'h4;
        endcase
      // R4 red and green, blue off
      end else if (setup1_r[`ASC_F_DUAL]) begin
        chanEnable <= 3'h3;
      end else begin
        chanEnable <= 3'h7;
      end
      // codes 00 and 01 both give mid-scale
      // R5 zero-input code
      case (ampOffsetSel)
        2'h2:    zeroInputCode <= `ASC_CODE_FULL;
        2'h3:    zeroInputCode <= `ASC_CODE_ZERO;
        default: zeroInputCode <= `ASC_CODE_MID;
      endcase
      // R8 compatible timing select
      compatTiming <= compat;
      // R7 fastest bit gated by compat
      compatMode4 <= compat && setup1_r[`ASC_F_FASTEST];
      // in normal timing the clamp role stays idle; the pin is then read
      // by other logic outside this block
      // R10 clamp from pin
      clampAutocycle <= compat && resetSamplePulse;
    end
  end

  // formatter next state: load a new sample or shift the next slot
  // a new sample always wins over the slots still pending; the host must
  // space samples at least one slot count apart or lose the tail
  // slot count after the first: nibble 3, 8+8 one, upper byte none
  always @* begin
    word_nxt = word_r;
    slot_nxt = slot_r;
    if (adcValid && enable) begin
      // inversion is applied once at load so every slot of a sample agrees
      // R12 invert output data
      word_nxt = outputInvert ? ~adcData : adcData;
      slot_nxt = fmtNibble ? 2'h3 : (fmtByte ? 2'h0 : 2'h1);
    end else if (slot_r != 2'h0) begin
      word_nxt = fmtNibble ? {word_r[11:0], 4'h0} : {word_r[7:0], 8'h00};
      slot_nxt = slot_r - 2'h1;
    end
  end

  // output data pins, upper part first
  // opData is taken from word_nxt so the first slot appears one edge
  // after the sample, not two
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_r   <= 16'h0000;
      slot_r   <= 2'h0;
      opData   <= 8'h00;
      opStrobe <= 1'b0;
    end else if (ce) begin
      word_r   <= word_nxt;
      slot_r   <= slot_nxt;
      opStrobe <= (adcValid && enable) || (slot_r != 2'h0);
      // R11 nibble in low bits, else byte
      if (fmtNibble) begin
        opData <= {4'h0, word_nxt[15:12]};
      end else begin
        opData <= word_nxt[15:8];
      end
    end
  end

endmodule

// [sim/asc_scan_model.sv]
// scanner controller model that latches pixel data from the output pins
`timescale 1ns/1ps
module asc_scan_model (
  input  wire        clk,
  input  wire [7:0]  opData,
  input  wire        opStrobe,
  input  wire        opOe_n,
  output reg  [31:0] cap,
  output reg  [7:0]  n
);
  initial begin
    cap = 32'h0;
    n = 8'h0;
  end
  // released pins carry nothing, so slots are only taken while the pins are driven
  always @(posedge clk) begin
    if (opStrobe && !opOe_n) begin
      cap <= {cap[23:0], opData};
      n <= n + 8'h1;
    end
  end
endmodule

// [sim/asc_setup_chk.sv]
// concurrent checks on the afe setup block ports
`timescale 1ns/1ps
module asc_setup_chk (
  input wire        clk,
  input wire        nrst,
  input wire        powerDown,
  input wire [2:0]  chanEnable,
  input wire [15:0] zeroInputCode,
  input wire        compatTiming,
  input wire        compatMode4,
  input wire        resetSamplePulse,
  input wire        clampAutocycle,
  input wire [15:0] adcData,
  input wire        adcValid,
  input wire        outputEnableNPin,
  input wire [7:0]  opData,
  input wire        opStrobe,
  input wire        opOe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a sample accepted in normal timing
  sequence s_take;
    adcValid && !powerDown && !compatTiming;
  endsequence
  property p_pdOff;
    powerDown |-> chanEnable == 3'h0;
  endproperty
  a_pdOff: assert property (p_pdOff) else $error("channels on while down");
  property p_zero;
    zeroInputCode inside {16'h7fff, 16'hffff, 16'h0000};
  endproperty
  a_zero: assert property (p_zero) else $error("bad zero code");
  property p_fast;
    !compatTiming |-> !compatMode4;
  endproperty
  a_fast: assert property (p_fast) else $error("fastest mode without compat");
  property p_clampOn;
    compatTiming ##1 compatTiming |-> clampAutocycle == $past(resetSamplePulse);
  endproperty
  a_clampOn: assert property (p_clampOn) else $error("clamp not following pulse");
  property p_clampOff;
    !compatTiming ##1 !compatTiming |-> !clampAutocycle;
  endproperty
  a_clampOff: assert property (p_clampOff) else $error("clamp active in normal");
  property p_slot;
    s_take |=> opStrobe;
  endproperty
  a_slot: assert property (p_slot) else $error("no output slot");
  property p_byte;
    s_take |=> (opData ^ $past(adcData[15:8])) inside {8'h00, 8'hff};
  endproperty
  a_byte: assert property (p_byte) else $error("upper byte wrong");
  property p_oe;
    !opOe_n |-> !outputEnableNPin;
  endproperty
  a_oe: assert property (p_oe) else $error("pins driven with pin high");
endmodule
bind asc_setup_ctrl asc_setup_chk i_chk (.clk, .nrst, .powerDown, .chanEnable,
  .zeroInputCode, .compatTiming, .compatMode4, .resetSamplePulse, .clampAutocycle,
  .adcData, .adcValid, .outputEnableNPin, .opData, .opStrobe, .opOe_n);

// [sim/tb.sv]
// self-checking bench for the afe setup block
`timescale 1ns/1ps
module tb;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready, adcValid;
  logic        resetSamplePulse, outputEnableNPin;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [15:0] adcData;
  logic [1:0]  inputSelect;
  wire         awready, wready, bvalid, arready, rvalid, powerDown, doubleSampleEn;
  wire         compatTiming, compatMode4, clampAutocycle, opStrobe, opOe_n;
  wire  [31:0] rdata, cap;
  wire  [15:0] zeroInputCode;
  wire  [1:0]  bresp, rresp;
  wire  [2:0]  chanEnable;
  wire  [7:0]  opData, n;
  int          mismatches, checks, t;
  logic [1:0]  lastResp;
  logic [15:0] zt [4] = '{16'h7fff, 16'h7fff, 16'hffff, 16'h0000};
  asc_setup_ctrl i_dut (.clk, .nrst, .ce(1'b1), .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .inputSelect, .powerDown, .doubleSampleEn, .chanEnable,
    .zeroInputCode, .compatTiming, .compatMode4, .resetSamplePulse, .clampAutocycle,
    .adcData, .adcValid, .outputEnableNPin, .opData, .opStrobe, .opOe_n);
  asc_scan_model i_scan (.clk, .opData, .opStrobe, .opOe_n, .cap, .n);
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task wrap_up;
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask
  // bounded wait: a hung handshake ends the run
  task step;
    @(posedge clk);
    t++;
    if (t > 100) begin
      mismatches++;
      wrap_up;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    t = 0;
    do begin
      step;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    lastResp = bresp;
    repeat (2) @(posedge clk);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    t = 0;
    do begin
      step;
      if (arready) arvalid <= 0;
    end while (!rvalid);
    rready <= 0;
    chk("rdata", e, rdata);
    chk("rresp", {30'h0, r}, {30'h0, rresp});
  endtask
  // control bits packed as power, sampling, channels, compat, fastest
  task ctl(input logic [7:0] v, input logic [6:0] e, input logic [6:0] m);
    wr(4'h0, v);
    chk("ctl", {25'h0, e & m}, {25'h0, m & {powerDown, doubleSampleEn, chanEnable,
      compatTiming, compatMode4}});
  endtask
  task smp(input logic [7:0] f, input logic [31:0] e, input logic [31:0] m, input logic [7:0] k);
    logic [7:0] n0;
    wr(4'h4, f);
    n0 = n;
    adcData <= 16'hb4e1;
    adcValid <= 1;
    @(posedge clk);
    adcValid <= 0;
    repeat (6) @(posedge clk);
    chk("cap", e & m, cap & m);
    chk("slots", {24'h0, k}, {24'h0, n - n0});
  endtask
  initial begin
    {nrst, awvalid, wvalid, bready, arvalid, rready, adcValid, resetSamplePulse} = 0;
    {outputEnableNPin, awaddr, araddr, wdata, adcData, inputSelect} = 0;
    repeat (20) @(posedge clk);
    nrst <= 1;
    rd(4'h0, 32'h3, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    rd(4'hc, 32'h0, 2'h2);
    ctl(8'h02, 7'b1000000, 7'b1011100);
    ctl(8'h01, 7'b0011100, 7'h7f);
    ctl(8'h0b, 7'b0101100, 7'h7f);
    ctl(8'h43, 7'b0111100, 7'h7f);
    ctl(8'hc3, 7'b0111111, 7'h7f);
    rd(4'h8, 32'hd7, 2'h0);
    wr(4'h8, 8'h00);
    chk("bresp", 32'h0, {30'h0, lastResp});
    wr(4'hc, 8'h55);
    chk("bresp", 32'h2, {30'h0, lastResp});
    rd(4'h8, 32'hd7, 2'h0);
    rd(4'h0, 32'hc3, 2'h0);
    @(posedge clk);
    resetSamplePulse <= 1;
    @(posedge clk);
    resetSamplePulse <= 0;
    #1 chk("clamp", 32'h1, {31'h0, clampAutocycle});
    smp(8'h03, 32'h0b040e01, 32'h0f0f0f0f, 8'h4);
    ctl(8'h03, 7'b0111100, 7'h7f);
    smp(8'h00, 32'hb4e1, 32'hffff, 8'h2);
    smp(8'h02, 32'hb4e1, 32'hffff, 8'h2);
    smp(8'h01, 32'hb4, 32'hff, 8'h1);
    smp(8'h03, 32'hb4e1, 32'hffff, 8'h2);
    smp(8'h04, 32'h4b1e, 32'hffff, 8'h2);
    for (int i = 0; i < 4; i++) begin
      inputSelect <= i[1:0];
      ctl(8'h07, {2'b0, ((i > 2) ? 3'b100 : (3'b001 << i)), 2'b0}, 7'b0011100);
    end
    for (int k = 0; k < 4; k++) begin
      wr(4'h0, {2'b0, k[1:0], 4'h3});
      chk("zero", {16'h0, zt[k]}, {16'h0, zeroInputCode});
    end
    for (int k = 0; k < 4; k++) begin
      wr(4'h4, {4'h0, k[1], 3'h0});
      outputEnableNPin <= k[0];
      @(posedge clk);
      #1 chk("oe", {31'h0, k != 0}, {31'h0, opOe_n});
    end
    // a second reset in mid-run must bring back the defaults
    @(posedge clk);
    nrst <= 0;
    @(posedge clk);
    nrst <= 1;
    rd(4'h0, 32'h3, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    wrap_up;
  end
endmodule
